// [core/gpio_port_pin_mux.sv]
// Summary of operation
// - six 256-byte port windows, 0x100 apart
// - mode, type, selects, pull at fixed offsets
// - read-only input levels, reset to ones
// - output data plus set and clear registers
// - write mask and debounce registers, reset zero
// - 32, 16 and 8-bit accesses accepted
// - 2-bit mode: input, output, alternate, off
// - off mode: no drive, input reads one
// - crystal pins of port e locked while clocking
// - port e pins 1:0 modes reset only by power-on
// - debug and boot pins reset to alternate
// - port a pins 7:6 reset to input
// - type bit: push-pull or open-drain
// - 4-bit function code per pin, two registers
// - port a codes zero to eight valid
// - other ports codes zero to seven valid
// - lcd pins become common or segment by duty
`timescale 1ns/10ps
`default_nettype none

module gpio_port_pin_mux
   import gpio_pkg::*;
(
   // clock and resets
   input  wire logic                       ref_clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       power_on_rst_in,
   // register port
   input  wire bus_req_t                   bus_in,
   output logic [31:0]                     rdata_out,
   // system clock source
   input  wire logic                       main_crystal_clock_sel_in,
   input  wire logic                       sub_crystal_clock_sel_in,
   // display controller
   input  wire logic [3:0]                 lcd_com_count_in,
   output logic [5:0]                      lcd_common_out,
   // package pins
   input  wire logic [NUM_PORTS-1:0][15:0] pad_in,
   output pad_t [NUM_PORTS-1:0]            pad_out,
   // peripheral side
   input  wire af_src_t [NUM_PORTS-1:0]    af_src_in,
   output logic [NUM_PORTS-1:0][15:0]      periph_level_out,
   output logic [NUM_PORTS-1:0][63:0]      func_code_out,
   output logic [NUM_PORTS-1:0][31:0]      pull_select_out,
   output logic [NUM_PORTS-1:0][31:0]      debounce_ctl_out
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      port_regs_t [NUM_PORTS-1:0]    regs;
      logic [NUM_PORTS-1:0][15:0]    sync1;
      logic [NUM_PORTS-1:0][15:0]    sync2;
      pad_t [NUM_PORTS-1:0]          pad;
      logic [NUM_PORTS-1:0][15:0]    periph;
      logic [5:0]                    lcd_com;
      logic [31:0]                   rdata;
   } state_t;

   state_t state_q;
   state_t state_d;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wdata,
                                         input logic [3:0]  be);
      logic [31:0] m;
      m     = lane_mask(be);
      merge = (wdata & m) | (old & ~m);
   endfunction

   function automatic logic [31:0] mode_reset(input logic [2:0] p);
      case (p)
         PORT_A:  mode_reset = MODE_RST_A;
         PORT_C:  mode_reset = MODE_RST_C;
         PORT_D:  mode_reset = MODE_RST_D;
         default: mode_reset = MODE_RST;
      endcase
   endfunction

   // reserved codes leave the pin undriven
   function automatic logic code_valid(input logic [2:0] p,
                                       input logic [3:0] code);
      if (p == PORT_A) begin
         code_valid = (code <= FUNC_MAX_A);
      end else begin
         code_valid = (code <= FUNC_MAX);
      end
   endfunction

   function automatic logic [3:0] pin_code(input port_regs_t r,
                                           input int unsigned pin);
      if (pin < 8) begin
         pin_code = r.fsel_lo[4*pin +: 4];
      end else begin
         pin_code = r.fsel_hi[4*(pin-8) +: 4];
      end
   endfunction

   function automatic logic [1:0] pin_mode(input port_regs_t r,
                                           input int unsigned pin);
      pin_mode = r.mode[2*pin +: 2];
   endfunction

   // lcd-capable pins of port c and their common line index
   function automatic logic [3:0] lcd_pin(input int unsigned k);
      case (k)
         0:       lcd_pin = 4'h2;
         1:       lcd_pin = 4'h3;
         2:       lcd_pin = 4'ha;
         3:       lcd_pin = 4'hb;
         4:       lcd_pin = 4'hc;
         default: lcd_pin = 4'hd;
      endcase
   endfunction

   function automatic logic [3:0] lcd_com_idx(input int unsigned k);
      case (k)
         0:       lcd_com_idx = 4'h2;
         1:       lcd_com_idx = 4'h3;
         2:       lcd_com_idx = 4'h4;
         3:       lcd_com_idx = 4'h5;
         4:       lcd_com_idx = 4'h6;
         default: lcd_com_idx = 4'h7;
      endcase
   endfunction

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic        hit;
      logic [2:0]  port;
      logic [7:0]  ofs;
      logic [31:0] wm;
      logic [31:0] lock_mode;
      logic [31:0] lock_fsel;
      logic [31:0] nv;
      logic [1:0]  mode;
      logic [3:0]  code;
      logic        val;
      logic        en;
      port_regs_t  r;

      hit       = 1'b0;
      port      = 3'h0;
      ofs       = 8'h00;
      wm        = 32'h0000_0000;
      lock_mode = 32'h0000_0000;
      lock_fsel = 32'h0000_0000;
      nv        = 32'h0000_0000;
      mode      = 2'b00;
      code      = 4'h0;
      val       = 1'b0;
      en        = 1'b0;
      r         = '0;
      state_d   = state_q;

      // address decode
      port = bus_in.addr[10:8];
      ofs  = bus_in.addr[7:0] & 8'hfc;
      hit  = (bus_in.addr[31:11] == PORT_BASE_ADDR[31:11])
             && (port < NUM_PORTS_IDX);
      // byte lanes for set and clear
      wm   = lane_mask(bus_in.be);

      // pin synchronisers
      state_d.sync1 = pad_in;
      state_d.sync2 = state_q.sync1;

      // ***********************************************************
      // register writes
      // ***********************************************************
      if (hit && bus_in.wr) begin
         r = state_q.regs[port];
         // crystal pins frozen while clocking
         if (port == PORT_E) begin
            if (sub_crystal_clock_sel_in) begin
               lock_mode = lock_mode | MODE_LOCK_SUB;
               lock_fsel = lock_fsel | FSEL_LOCK_SUB;
            end
            if (main_crystal_clock_sel_in) begin
               lock_mode = lock_mode | MODE_LOCK_MAIN;
               lock_fsel = lock_fsel | FSEL_LOCK_MAIN;
            end
         end
         case (ofs)
            OFS_MODE: begin
               nv     = merge(r.mode, bus_in.wdata, bus_in.be);
               r.mode = (nv & ~lock_mode) | (r.mode & lock_mode);
            end
            OFS_TYPE: begin
               nv    = merge({16'h0000, r.typ}, bus_in.wdata, bus_in.be);
               r.typ = nv[15:0];
            end
            OFS_FSEL_LO: begin
               nv        = merge(r.fsel_lo, bus_in.wdata, bus_in.be);
               r.fsel_lo = (nv & ~lock_fsel) | (r.fsel_lo & lock_fsel);
            end
            OFS_FSEL_HI: begin
               r.fsel_hi = merge(r.fsel_hi, bus_in.wdata, bus_in.be);
            end
            OFS_PULL: begin
               r.pull = merge(r.pull, bus_in.wdata, bus_in.be);
            end
            OFS_OUT_LVL: begin
               // masked bits hold their output value
               nv = merge({16'h0000, r.out_lvl}, bus_in.wdata, bus_in.be);
               r.out_lvl = (nv[15:0] & ~r.wmask) | (r.out_lvl & r.wmask);
            end
            OFS_BIT_SET: begin
               nv = bus_in.wdata & wm;
               r.out_lvl = r.out_lvl | nv[15:0];
            end
            OFS_BIT_CLR: begin
               nv = bus_in.wdata & wm;
               r.out_lvl = r.out_lvl & ~nv[15:0];
            end
            OFS_WMASK: begin
               nv      = merge({16'h0000, r.wmask}, bus_in.wdata, bus_in.be);
               r.wmask = nv[15:0];
            end
            OFS_DEBOUNCE: begin
               r.debounce = merge(r.debounce, bus_in.wdata, bus_in.be);
            end
            default: begin
               r = state_q.regs[port];
            end
         endcase
         state_d.regs[port] = r;
      end

      // ***********************************************************
      // register reads: data only in the cycle after the strobe
      // ***********************************************************
      state_d.rdata = 32'h0000_0000;
      if (hit && bus_in.rd) begin
         r = state_q.regs[port];
         case (ofs)
            OFS_MODE:     state_d.rdata = r.mode;
            OFS_TYPE:     state_d.rdata = {16'h0000, r.typ};
            OFS_FSEL_LO:  state_d.rdata = r.fsel_lo;
            OFS_FSEL_HI:  state_d.rdata = r.fsel_hi;
            OFS_PULL:     state_d.rdata = r.pull;
            OFS_IN_LVL:   state_d.rdata = {16'h0000, r.in_lvl};
            OFS_OUT_LVL:  state_d.rdata = {16'h0000, r.out_lvl};
            OFS_WMASK:    state_d.rdata = {16'h0000, r.wmask};
            OFS_DEBOUNCE: state_d.rdata = r.debounce;
            default:      state_d.rdata = 32'h0000_0000;
         endcase
      end

      // ***********************************************************
      // pin paths
      // ***********************************************************
      for (int p = 0; p < NUM_PORTS; p++) begin
         r = state_q.regs[p];
         for (int unsigned i = 0; i < PINS; i++) begin
            mode = pin_mode(r, i);
            code = pin_code(r, i);
            val  = 1'b0;
            en   = 1'b0;
            case (mode)
               MODE_OUTPUT: begin
                  val = r.out_lvl[i];
                  en  = 1'b1;
               end
               MODE_ALT: begin
                  if (code_valid(3'(p), code)) begin
                     val = af_src_in[p].o[i][code];
                     en  = af_src_in[p].oe[i][code];
                  end
               end
               default: begin
                  val = 1'b0;
                  en  = 1'b0;
               end
            endcase
            // open-drain only pulls low
            if (r.typ[i]) begin
               state_d.pad[p].o[i]  = 1'b0;
               state_d.pad[p].oe[i] = en & ~val;
            end else begin
               state_d.pad[p].o[i]  = val;
               state_d.pad[p].oe[i] = en;
            end
            // off pins read one, never float
            if (mode == MODE_OFF) begin
               state_d.regs[p].in_lvl[i] = 1'b1;
            end else begin
               state_d.regs[p].in_lvl[i] = state_q.sync2[p][i];
            end
            // idle high unless routed
            state_d.periph[p][i] = (mode == MODE_ALT) ?
                                   state_q.sync2[p][i] : 1'b1;
         end
      end

      // display common or segment by duty
      r = state_q.regs[PORT_C];
      for (int unsigned k = 0; k < 6; k++) begin
         mode = pin_mode(r, 32'(lcd_pin(k)));
         code = pin_code(r, 32'(lcd_pin(k)));
         state_d.lcd_com[k] = (mode == MODE_ALT) && (code == FUNC_LCD)
                              && (lcd_com_idx(k) < lcd_com_count_in);
      end

      // ***********************************************************
      // resets
      // ***********************************************************
      if (rst_in || power_on_rst_in) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            state_d.regs[p].mode     = mode_reset(3'(p));
            state_d.regs[p].typ      = TYPE_RST;
            state_d.regs[p].fsel_lo  = FSEL_RST;
            state_d.regs[p].fsel_hi  = FSEL_RST;
            state_d.regs[p].pull     = PULL_RST;
            state_d.regs[p].in_lvl   = IN_LVL_RST;
            state_d.regs[p].out_lvl  = OUT_LVL_RST;
            state_d.regs[p].wmask    = WMASK_RST;
            state_d.regs[p].debounce = DEBOUNCE_RST;
            // pins released during reset
            state_d.pad[p]           = '0;
            state_d.periph[p]        = 16'hffff;
         end
         // system reset keeps sub crystal modes (pins 1:0), main crystal pins reset
         if (!power_on_rst_in) begin
            state_d.regs[PORT_E].mode =
               (MODE_RST & ~MODE_KEEP_E)
               | (state_q.regs[PORT_E].mode & MODE_KEEP_E);
         end
         state_d.lcd_com = 6'h00;
         state_d.rdata   = 32'h0000_0000;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      state_q <= state_d;
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   always_comb begin
      rdata_out        = state_q.rdata;
      pad_out          = state_q.pad;
      periph_level_out = state_q.periph;
      lcd_common_out   = state_q.lcd_com;
      for (int p = 0; p < NUM_PORTS; p++) begin
         // both select words per port
         func_code_out[p]    = {state_q.regs[p].fsel_hi,
                                state_q.regs[p].fsel_lo};
         pull_select_out[p]  = state_q.regs[p].pull;
         debounce_ctl_out[p] = state_q.regs[p].debounce;
      end
   end

endmodule // gpio_port_pin_mux

`default_nettype wire

// [core/gpio_pkg.sv]
package gpio_pkg;

   // ****************************************************************
   // geometry and address map
   // ****************************************************************
   localparam int          NUM_PORTS      = 6;
   localparam int          PINS           = 16;
   localparam logic [2:0]  NUM_PORTS_IDX  = 3'h6;
   localparam logic [31:0] PORT_BASE_ADDR = 32'h3000_0000;
   localparam int          WINDOW_BYTES   = 256;
   localparam logic [2:0]  PORT_A         = 3'h0;
   localparam logic [2:0]  PORT_C         = 3'h2;
   localparam logic [2:0]  PORT_D         = 3'h3;
   localparam logic [2:0]  PORT_E         = 3'h4;

   localparam logic [7:0]  OFS_MODE       = 8'h00;
   localparam logic [7:0]  OFS_TYPE       = 8'h04;
   localparam logic [7:0]  OFS_FSEL_LO    = 8'h08;
   localparam logic [7:0]  OFS_FSEL_HI    = 8'h0c;
   localparam logic [7:0]  OFS_PULL       = 8'h10;
   localparam logic [7:0]  OFS_IN_LVL     = 8'h14;
   localparam logic [7:0]  OFS_OUT_LVL    = 8'h18;
   localparam logic [7:0]  OFS_BIT_SET    = 8'h1c;
   localparam logic [7:0]  OFS_BIT_CLR    = 8'h20;
   localparam logic [7:0]  OFS_WMASK      = 8'h24;
   localparam logic [7:0]  OFS_DEBOUNCE   = 8'h28;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [31:0] MODE_RST       = 32'hffff_ffff;
   localparam logic [31:0] MODE_RST_A     = 32'hffff_0fff;
   localparam logic [31:0] MODE_RST_C     = 32'hffff_ebff;
   localparam logic [31:0] MODE_RST_D     = 32'hffff_fbff;
   localparam logic [15:0] TYPE_RST       = 16'h0000;
   localparam logic [31:0] FSEL_RST       = 32'h0000_0000;
   localparam logic [31:0] PULL_RST       = 32'h0000_0000;
   localparam logic [15:0] IN_LVL_RST     = 16'hffff;
   localparam logic [15:0] OUT_LVL_RST    = 16'h0000;
   localparam logic [15:0] WMASK_RST      = 16'h0000;
   localparam logic [31:0] DEBOUNCE_RST   = 32'h0000_0000;

   // port e crystal pins: sub crystal mode bits kept over system reset, write locks
   localparam logic [31:0] MODE_KEEP_E    = 32'h0000_000f;
   localparam logic [31:0] MODE_LOCK_SUB  = 32'h0000_000f;
   localparam logic [31:0] MODE_LOCK_MAIN = 32'h0000_00f0;
   localparam logic [31:0] FSEL_LOCK_SUB  = 32'h0000_00ff;
   localparam logic [31:0] FSEL_LOCK_MAIN = 32'h0000_ff00;

   // ****************************************************************
   // encodings
   // ****************************************************************
   typedef enum logic [1:0] {
      MODE_INPUT  = 2'b00,
      MODE_OUTPUT = 2'b01,
      MODE_ALT    = 2'b10,
      MODE_OFF    = 2'b11
   } pin_mode_t;

   localparam logic [3:0]  FUNC_MAX_A     = 4'h8;
   localparam logic [3:0]  FUNC_MAX       = 4'h7;
   localparam logic [3:0]  FUNC_LCD       = 4'h7;
   localparam int          NUM_FUNCS      = 9;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0]  be;
      logic        wr;
      logic        rd;
   } bus_req_t;

   typedef struct packed {
      logic [15:0] o;
      logic [15:0] oe;
   } pad_t;

   typedef struct packed {
      logic [15:0][NUM_FUNCS-1:0] o;
      logic [15:0][NUM_FUNCS-1:0] oe;
   } af_src_t;

   typedef struct packed {
      logic [31:0] mode;
      logic [15:0] typ;
      logic [31:0] fsel_lo;
      logic [31:0] fsel_hi;
      logic [31:0] pull;
      logic [15:0] in_lvl;
      logic [15:0] out_lvl;
      logic [15:0] wmask;
      logic [31:0] debounce;
   } port_regs_t;

endpackage

// [test/gpio_monitor.sv]
`timescale 1ns/10ps
`default_nettype none

module gpio_monitor
   import gpio_pkg::*;
(
   // clock and resets
   input wire logic                       ref_clk_in,
   input wire logic                       rst_in,
   input wire logic                       power_on_rst_in,
   // register port and controls
   input wire bus_req_t                   bus_in,
   input wire logic [31:0]                rdata_out,
   input wire logic                       sub_crystal_clock_sel_in,
   input wire logic [3:0]                 lcd_com_count_in,
   input wire logic [5:0]                 lcd_common_out,
   // pins and peripheral side
   input wire pad_t [NUM_PORTS-1:0]       pad_out,
   input wire logic [NUM_PORTS-1:0][15:0] periph_level_out,
   input wire logic [NUM_PORTS-1:0][63:0] func_code_out,
   input wire logic [NUM_PORTS-1:0][31:0] pull_select_out,
   input wire logic [NUM_PORTS-1:0][31:0] debounce_ctl_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in || power_on_rst_in);

   sequence s_wr(a, m);
      bus_in.wr && bus_in.addr == a && bus_in.be == m;
   endsequence
   sequence s_rd_hole;
      bus_in.rd && (bus_in.addr[31:8] == 24'h300006 ||
                    bus_in.addr[7:0] > 8'h2b);
   endsequence

   property p_unmapped;
      s_rd_hole |=> rdata_out == 32'h0;
   endproperty
   property p_wo_zero;
      bus_in.rd && bus_in.addr[7:2] inside {6'h07, 6'h08}
         |=> rdata_out == 32'h0;
   endproperty
   property p_fsel;
      s_wr(32'h3000_0008, 4'hf)
         |=> ##1 func_code_out[0][31:0] == $past(bus_in.wdata, 2);
   endproperty
   property p_lane;
      s_wr(32'h3000_0210, 4'h2) |=>
         pull_select_out[2][15:8] == $past(bus_in.wdata[15:8]) &&
         $stable(pull_select_out[2][7:0]) &&
         $stable(pull_select_out[2][31:16]);
   endproperty
   property p_dbc;
      s_wr(32'h3000_0528, 4'hf)
         |=> debounce_ctl_out[5] == $past(bus_in.wdata);
   endproperty
   property p_lock;
      s_wr(32'h3000_0408, 4'hf) and sub_crystal_clock_sel_in
         |-> ##1 $stable(func_code_out[4][7:0])
             ##1 $stable(func_code_out[4][7:0]);
   endproperty
   property p_lcd;
      lcd_common_out != 6'h0 |-> $past(lcd_com_count_in) > 4'h2 &&
         (!lcd_common_out[5] || $past(lcd_com_count_in) > 4'h7);
   endproperty
   property p_rst;
      disable iff (1'b0)
      rst_in |=> pad_out == '0 && periph_level_out == '1;
   endproperty

   a_unmapped: assert property (p_unmapped) else $error("hole read");
   a_wo_zero: assert property (p_wo_zero) else $error("wo read");
   a_fsel: assert property (p_fsel) else $error("fsel write");
   a_lane: assert property (p_lane) else $error("byte lane");
   a_dbc: assert property (p_dbc) else $error("debounce");
   a_lock: assert property (p_lock) else $error("crystal lock");
   a_lcd: assert property (p_lcd) else $error("lcd common");
   a_rst: assert property (p_rst) else $error("reset pins");
endmodule // gpio_monitor

bind gpio_port_pin_mux gpio_monitor gpio_monitor_i (.ref_clk_in, .rst_in,
   .power_on_rst_in, .bus_in, .rdata_out, .sub_crystal_clock_sel_in,
   .lcd_com_count_in, .lcd_common_out, .pad_out, .periph_level_out,
   .func_code_out, .pull_select_out, .debounce_ctl_out);

`default_nettype wire

// [test/pin_world.sv]
`timescale 1ns/10ps
`default_nettype none

module pin_world
   import gpio_pkg::*;
(
   // clock
   input  wire logic                       ref_clk_in,
   // design pins and outside drivers
   input  wire pad_t [NUM_PORTS-1:0]       pad_drive_in,
   input  wire logic [NUM_PORTS-1:0][15:0] ext_drive_in,
   input  wire logic [NUM_PORTS-1:0][15:0] ext_level_in,
   // resolved pin levels
   output logic [NUM_PORTS-1:0][15:0]      pad_level_out
);
   logic [15:0] float_q;

   initial float_q = 16'h5a5a;
   always @(posedge ref_clk_in) float_q <= ~float_q;

   // undriven pins float, never hold the old level
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++)
         for (int i = 0; i < 16; i++)
            pad_level_out[p][i] = pad_drive_in[p].oe[i] ?
               pad_drive_in[p].o[i] : ext_drive_in[p][i] ?
               ext_level_in[p][i] : float_q[i];
   end
endmodule // pin_world

`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none

module testbench
   import gpio_pkg::*;
;
   logic                       clk, rst, por, main_sel, sub_sel, rd_seen;
   bus_req_t                   bus;
   logic [31:0]                rdata, exp_q[$];
   logic [3:0]                 com_cnt;
   logic [5:0]                 lcd_com;
   logic [NUM_PORTS-1:0][15:0] pad_lvl, periph, ext_drv, ext_lvl;
   pad_t [NUM_PORTS-1:0]       pads;
   af_src_t [NUM_PORTS-1:0]    af;
   logic [NUM_PORTS-1:0][63:0] fcode;
   logic [NUM_PORTS-1:0][31:0] pull, dbc;
   int                         n_fail, comparisons;

   gpio_port_pin_mux gpio_port_pin_mux_i (.ref_clk_in(clk), .rst_in(rst),
      .power_on_rst_in(por), .bus_in(bus), .rdata_out(rdata),
      .main_crystal_clock_sel_in(main_sel),
      .sub_crystal_clock_sel_in(sub_sel), .lcd_com_count_in(com_cnt),
      .lcd_common_out(lcd_com), .pad_in(pad_lvl), .pad_out(pads),
      .af_src_in(af), .periph_level_out(periph), .func_code_out(fcode),
      .pull_select_out(pull), .debounce_ctl_out(dbc));
   pin_world pin_world_i (.ref_clk_in(clk), .pad_drive_in(pads),
      .ext_drive_in(ext_drv), .ext_level_in(ext_lvl),
      .pad_level_out(pad_lvl));

   // ****************************************************************
   // bus tasks and checking
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, d, input logic [3:0] be = 4'hf);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, be: 4'hf, wr: 1'b0, rd: 1'b1};
      exp_q.push_back(e);
      @(posedge clk);
      bus.rd <= 1'b0;
   endtask

   always @(posedge clk) begin
      if (rd_seen === 1'b1)
         chk(rdata, exp_q.pop_front());
      rd_seen <= bus.rd;
   end

   task automatic pin(input int p, input logic [15:0] eoe, eo);
      @(posedge clk);
      @(negedge clk);
      chk({pads[p].oe, pads[p].o & pads[p].oe}, {eoe, eo & eoe});
   endtask

   task automatic do_rst(input logic po);
      @(posedge clk);
      rst <= !po;
      por <= po;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
   endtask

   function automatic logic [31:0] ad(input int p, input logic [7:0] o);
      return PORT_BASE_ADDR + (32'(p) << 8) + {24'h0, o};
   endfunction

   function automatic logic [31:0] rst_val(input int p, logic [7:0] o);
      if (o == OFS_IN_LVL)
         return 32'h0000_ffff;
      if (o != OFS_MODE)
         return 32'h0;
      return p == 0 ? 32'hffff_0fff : p == 2 ? 32'hffff_ebff :
             p == 3 ? 32'hffff_fbff : 32'hffff_ffff;
   endfunction

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      #400000;
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim;
   end

   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      logic [15:0] r, s, c, v;
      logic [8:0]  ao, ae;
      logic        ok;
      {rst, por, main_sel, sub_sel, com_cnt} = {2'b11, 6'h0};
      bus = '0;
      af = '0;
      ext_drv = '1;
      ext_lvl = '1;
      n_fail = 0;
      comparisons = 0;
      void'($urandom(83));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      for (int p = 0; p < NUM_PORTS; p++)
         for (int o = 0; o <= 8'h2c; o += 4)
            rd(ad(p, 8'(o)), rst_val(p, 8'(o)));
      rd(32'h3000_0600, 32'h0);
      $display("test reset values done");
      {r, s, c} = {16'($urandom), 16'($urandom), 16'($urandom)};
      ext_drv[1:0] <= '0;
      wr(ad(1, OFS_MODE), 32'h5555_5555);
      wr(ad(1, OFS_OUT_LVL), {16'h0, r});
      pin(1, 16'hffff, r);
      wr(ad(1, OFS_BIT_SET), {16'h0, s});
      wr(ad(1, OFS_BIT_CLR), {16'h0, c});
      v = (r | s) & ~c;
      rd(ad(1, OFS_OUT_LVL), {16'h0, v});
      wr(ad(1, OFS_TYPE), 32'hffff_ffff);
      rd(ad(1, OFS_TYPE), 32'h0000_ffff);
      pin(1, ~v, 16'h0);
      wr(ad(1, OFS_MODE), 32'h0);
      ext_drv[1] <= '1;
      ext_lvl[1] <= r;
      repeat (4) @(posedge clk);
      rd(ad(1, OFS_IN_LVL), {16'h0, r});
      wr(ad(1, OFS_MODE), 32'hffff_ffff);
      repeat (4) @(posedge clk);
      rd(ad(1, OFS_IN_LVL), 32'h0000_ffff);
      pin(1, 16'h0, 16'h0);
      ext_drv[1] <= '0;
      $display("test output modes done");
      for (int p = 0; p < 2; p++) begin
         wr(ad(p, OFS_MODE), 32'haaaa_aaaa);
         wr(ad(p, OFS_TYPE), 32'h0);
         for (int k = 0; k < 16; k++) begin
            wr(ad(p, OFS_FSEL_LO), 32'(k) << 8);
            {ao, ae} = {9'($urandom), 9'($urandom)};
            af[p].o[2] <= ao;
            af[p].oe[2] <= ae;
            ok = k <= (p == 0 ? 8 : 7) && ae[k % 9];
            @(posedge clk);
            @(negedge clk);
            chk({pads[p].oe[2], pads[p].oe[2] & pads[p].o[2]},
                {ok, ok & ao[k % 9]});
         end
      end
      $display("test function codes done");
      wr(ad(2, OFS_PULL), 32'h1234_5678, 4'h2);
      wr(ad(2, OFS_PULL), 32'hdead_beef, 4'hc);
      rd(ad(2, OFS_PULL), 32'hdead_5600);
      wr(ad(5, OFS_DEBOUNCE), {r, s});
      rd(ad(5, OFS_DEBOUNCE), {r, s});
      wr(ad(5, OFS_WMASK), 32'hffff_ffff);
      rd(ad(5, OFS_WMASK), 32'h0000_ffff);
      sub_sel <= 1'b1;
      wr(ad(4, OFS_MODE), 32'h0);
      rd(ad(4, OFS_MODE), 32'h0000_000f);
      wr(ad(4, OFS_FSEL_LO), 32'h1111_1111);
      rd(ad(4, OFS_FSEL_LO), 32'h1111_1100);
      {main_sel, sub_sel} <= 2'b10;
      wr(ad(4, OFS_MODE), 32'hffff_ffff);
      rd(ad(4, OFS_MODE), 32'hffff_ff0f);
      main_sel <= 1'b0;
      wr(ad(4, OFS_MODE), 32'h0);
      do_rst(1'b0);
      rd(ad(4, OFS_MODE), 32'hffff_fff0);
      rd(ad(0, OFS_MODE), 32'hffff_0fff);
      rd(ad(2, OFS_MODE), 32'hffff_ebff);
      do_rst(1'b1);
      rd(ad(4, OFS_MODE), 32'hffff_ffff);
      $display("test locks and resets done");
      wr(ad(2, OFS_MODE), 32'haaaa_aaaa);
      wr(ad(2, OFS_FSEL_LO), 32'h0000_7700);
      wr(ad(2, OFS_FSEL_HI), 32'h0077_7700);
      ext_lvl[2] <= r;
      for (int n = 0; n < 9; n++) begin
         com_cnt <= 4'(n);
         @(posedge clk);
         @(negedge clk);
         for (int k = 0; k < 6; k++)
            chk({31'h0, lcd_com[k]}, {31'h0, k + 2 < n});
         @(posedge clk);
      end
      chk(periph[2], {16'h0, r});
      $display("test display commons done");
      repeat (3) @(posedge clk);
      end_sim;
   end
endmodule // testbench

`default_nettype wire
